// ---- logic/pss_pkg.sv ----
package pss_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 40_000_000;
	localparam int TICK_HZ         = 1_000;
	localparam int PRESCALE        = CLK_HZ / TICK_HZ;
	localparam int RESET_HOLD_MS   = 50;
	localparam int DOMAIN_STEP_MS  = 2;
	localparam int SETTLE_MS       = 5;
	localparam int SYNC_STAGES     = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic RST_OUT_N_RESET  = 1'b0;
	localparam logic BATT_FLT_N_RESET = 1'b0;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PSS_HOLD    = 2'b00,
		PSS_RUN     = 2'b01
	} pss_state_t;
endpackage : pss_pkg

// ---- logic/pss_sync.sv ----
`timescale 1ns/1ps
module pss_sync
	import pss_pkg::*;
#(
	parameter int WIDTH = 3
)
(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             srst,
	// raw levels and synchronised levels
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] synced
);
	// ----------------------------------------------------------------
	// two-stage synchroniser; first stage only feeds the second
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} pss_sync_state_t;

	pss_sync_state_t state;
	pss_sync_state_t next_state;

	initial
	begin
		if (WIDTH < 1)
			$error("pss_sync: WIDTH must be at least 1");
	end

	always_comb
	begin
		next_state      = state;
		next_state.meta = raw;
		next_state.sync = state.meta;
	end

	// reset input idles high, so ones avoid a false request; enables read high are ignored while reset holds
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			state <= '1;
		else
			state <= next_state;
	end

	assign synced = state.sync;
endmodule : pss_sync

// ---- logic/pss_sequencer.sv ----
`timescale 1ns/1ps
module pss_sequencer
	import pss_pkg::*;
#(
	parameter int PRESCALE_DIV = PRESCALE,
	parameter int HOLD_MS      = RESET_HOLD_MS,
	parameter int HV_DOMAINS   = 4,
	parameter int LV_DOMAINS   = 3,
	parameter int STEP_MS      = DOMAIN_STEP_MS,
	parameter int SETTLE_TIME  = SETTLE_MS
)
(
	// clock and reset (srst models the backup supply becoming valid)
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	// processor side pins
	input  wire logic                  reset_in_n,
	input  wire logic                  high_voltage_enable,
	input  wire logic                  low_voltage_enable,
	input  wire logic                  low_voltage_enable_serial,
	output logic                       reset_out_n,
	// battery monitor
	input  wire logic                  battery_above_threshold,
	output logic                       battery_fault_n,
	// domain options and controls
	input  wire logic                  delay_option,
	output logic                       backup_clock_regulator,
	output logic                       first_linear_regulator,
	output logic [HV_DOMAINS-1:0]      hv_domain_on,
	output logic [LV_DOMAINS-1:0]      lv_domain_on,
	// per-domain good flags for the serial interface
	output logic [HV_DOMAINS-1:0]      hv_domain_good,
	output logic [LV_DOMAINS-1:0]      lv_domain_good
);
	localparam int TICK_W = $clog2(PRESCALE_DIV + 1);
	localparam int MS_W   = 8;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		pss_state_t            mode;
		logic [TICK_W-1:0]     prescale;
		logic                  tick;
		logic [MS_W-1:0]       hold_ms;
		logic [MS_W-1:0]       hv_ms;
		logic [MS_W-1:0]       lv_ms;
		logic                  rst_out_n;
		logic                  batt_n;
		logic [HV_DOMAINS-1:0] hv_on;
		logic [LV_DOMAINS-1:0] lv_on;
	} pss_seq_state_t;

	pss_seq_state_t state;
	pss_seq_state_t next_state;
	logic [2:0]     pins;
	logic           rin_n;
	logic           hv_en;
	logic           lv_en;

	initial
	begin
		if (PRESCALE_DIV < 2 || HOLD_MS < 1 || HOLD_MS > 255 || HV_DOMAINS < 1 || LV_DOMAINS < 1)
			$error("pss_sequencer: parameter out of range");
		if (STEP_MS * HV_DOMAINS + SETTLE_TIME > 255)
			$error("pss_sequencer: stagger too long for counter");
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	pss_sync #(.WIDTH(3)) u_sync
	(
		.clk_sys (clk_sys),
		.srst    (srst),
		.raw     ({reset_in_n, high_voltage_enable, low_voltage_enable}),
		.synced  (pins)
	);

	assign rin_n = pins[2];
	assign hv_en = pins[1];
	assign lv_en = pins[0] | low_voltage_enable_serial;

	function automatic logic [MS_W-1:0] sat_inc(input logic [MS_W-1:0] v, input logic t);
		sat_inc = (t && v != '1) ? v + 8'h01 : v;
	endfunction : sat_inc

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state      = state;
		next_state.tick = 1'b0;
		// millisecond tick; a low-rate enable, not a clock
		if (state.prescale == TICK_W'(PRESCALE_DIV - 1))
		begin
			next_state.prescale = '0;
			next_state.tick     = 1'b1;
		end
		else
			next_state.prescale = state.prescale + 1'b1;

		next_state.batt_n = battery_above_threshold;

		case (state.mode)
			PSS_HOLD:
			begin
				next_state.rst_out_n = 1'b0;
				next_state.hv_on     = '0;
				next_state.lv_on     = '0;
				next_state.hold_ms   = sat_inc(state.hold_ms, state.tick);
				// counting from the first whole tick gives at least HOLD_MS
				if (rin_n && state.hold_ms >= MS_W'(HOLD_MS + 1))
				begin
					next_state.mode      = PSS_RUN;
					next_state.rst_out_n = 1'b1;
				end
			end
			PSS_RUN:
			begin
				// high-voltage domains: first linear regulator first, rest staggered
				if (hv_en)
				begin
					next_state.hv_ms = sat_inc(state.hv_ms, state.tick);
					for (int i = 0; i < HV_DOMAINS; i++)
						next_state.hv_on[i] = (i == 0) || !delay_option ||
							(state.hv_ms >= MS_W'(STEP_MS * i));
				end
				else
				begin
					next_state.hv_ms = '0;
					next_state.hv_on = '0;
				end
				if (lv_en)
				begin
					next_state.lv_ms = sat_inc(state.lv_ms, state.tick);
					next_state.lv_on = '1;
				end
				else
				begin
					next_state.lv_ms = '0;
					next_state.lv_on = '0;
				end
			end
			default:
				next_state.mode = PSS_HOLD;
		endcase

		// a reset request restarts the whole bring-up, supplies dropped
		if (!rin_n)
		begin
			next_state.mode      = PSS_HOLD;
			next_state.rst_out_n = 1'b0;
			next_state.hold_ms   = '0;
			next_state.hv_on     = '0;
			next_state.lv_on     = '0;
			next_state.hv_ms     = '0;
			next_state.lv_ms     = '0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state           <= '0;
			state.mode      <= PSS_HOLD;
			state.rst_out_n <= RST_OUT_N_RESET;
			state.batt_n    <= BATT_FLT_N_RESET;
		end
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reset_out_n            = state.rst_out_n;
	assign battery_fault_n        = state.batt_n;
	assign backup_clock_regulator = 1'b1;
	assign first_linear_regulator = state.hv_on[0];
	assign hv_domain_on           = state.hv_on;
	assign lv_domain_on           = state.lv_on;

	// good only after a settle time; reading during ramp shows not good
	always_comb
	begin
		for (int i = 0; i < HV_DOMAINS; i++)
			hv_domain_good[i] = state.hv_on[i] &&
				(state.hv_ms >= MS_W'(SETTLE_TIME + (delay_option ? STEP_MS * i : 0)));
		for (int j = 0; j < LV_DOMAINS; j++)
			lv_domain_good[j] = state.lv_on[j] && (state.lv_ms >= MS_W'(SETTLE_TIME));
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	int unsigned low_cycles;
	always_ff @(posedge clk_sys)
	begin
		if (srst || state.rst_out_n)
			low_cycles <= 0;
		else
			low_cycles <= low_cycles + 1;
	end

	sequence release_seq;
		!state.rst_out_n ##1 state.rst_out_n;
	endsequence

	reset_min_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(state.rst_out_n) |-> $past(low_cycles) >= HOLD_MS * PRESCALE_DIV)
		else $error("reset output released too early");
	reset_in_force_a: assert property (@(posedge clk_sys) disable iff (srst)
		!rin_n |=> !reset_out_n)
		else $error("reset input did not force reset output low");
	batt_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
		battery_above_threshold |=> battery_fault_n)
		else $error("battery fault not released");
	batt_fault_low_a: assert property (@(posedge clk_sys) disable iff (srst)
		!battery_above_threshold |=> !battery_fault_n)
		else $error("battery fault not flagged");
	hold_domains_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		!reset_out_n |-> (hv_domain_on == '0 && lv_domain_on == '0))
		else $error("domains on during reset");
	first_ldo_first_a: assert property (@(posedge clk_sys) disable iff (srst)
		hv_domain_on != '0 |-> first_linear_regulator &&
			((hv_domain_on + HV_DOMAINS'(1)) & hv_domain_on) == '0)
		else $error("high-voltage domains not on in turn");
	lv_enable_a: assert property (@(posedge clk_sys) disable iff (srst)
		reset_out_n && low_voltage_enable_serial && rin_n |=> lv_domain_on == '1)
		else $error("low-voltage domains not enabled");
	release_clean_a: assert property (@(posedge clk_sys) disable iff (srst)
		release_seq |-> $past(rin_n))
		else $error("released while reset input low");
	tick_period_a: assert property (@(posedge clk_sys) disable iff (srst)
		state.tick |=> !state.tick)
		else $error("tick lasted more than one cycle");
	good_settled_a: assert property (@(posedge clk_sys) disable iff (srst)
		lv_domain_good[0] |-> state.lv_ms >= MS_W'(SETTLE_TIME))
		else $error("good flag before settling");
endmodule : pss_sequencer

// ---- tb/pss_cpu_model.sv ----
`timescale 1ns/1ps
module pss_cpu_model
	import pss_pkg::*;
#(
	parameter int MS = 4
)
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       srst,
	// device side
	input  wire logic       reset_out_n,
	input  wire logic       battery_fault_n,
	input  wire logic [3:0] hv_good,
	input  wire logic [2:0] lv_good,
	// bench control and status
	input  wire logic       use_serial,
	output logic            hv_en,
	output logic            lv_en,
	output logic            lv_ser,
	output logic            ok,
	output logic            done
);
	int cnt;
	int ph;
	// the processor sits in reset while reset_out_n is low, so its enables drop
	always @(posedge clk_sys)
	begin
		if (srst || !reset_out_n)
		begin
			{hv_en, lv_en, lv_ser, ok, done} <= 5'h00;
			cnt <= 0;
			ph <= 0;
		end
		else if (battery_fault_n)
		begin
			cnt <= cnt + 1;
			if (ph == 0 && cnt == 10 * MS)
				{hv_en, cnt, ph} <= {1'b1, 32'h0, 32'h1};
			if (ph == 1 && cnt == 125 * MS)
				{lv_ser, lv_en, cnt, ph} <= {use_serial, !use_serial, 32'h0, 32'h2};
			if (ph == 2 && cnt == 125 * MS)
				{ok, done, ph} <= {&{hv_good, lv_good}, 1'b1, 32'h3};
		end
	end
endmodule : pss_cpu_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import pss_pkg::*;
;
	localparam int MS = 4;
	logic       clk_sys = 1'b0;
	logic       srst = 1'b1;
	logic       reset_in_n = 1'b1;
	logic       bat = 1'b0;
	logic       dly = 1'b0;
	logic       ser = 1'b0;
	logic       hv, lv, lvs, ok, done, rst_n, flt_n, bk, l1, bat_q;
	logic       srst_q = 1'b1;
	logic [3:0] hvon, hvg;
	logic [2:0] lvon, lvg;
	logic [31:0] seed = 32'h0000FF16;
	int         n_errors = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         t;

	always #12.5 clk_sys = ~clk_sys;

	pss_sequencer #(.PRESCALE_DIV(MS)) dut_u (.clk_sys(clk_sys), .srst(srst), .reset_in_n(reset_in_n),
		.high_voltage_enable(hv), .low_voltage_enable(lv), .low_voltage_enable_serial(lvs),
		.reset_out_n(rst_n), .battery_above_threshold(bat), .battery_fault_n(flt_n), .delay_option(dly),
		.backup_clock_regulator(bk), .first_linear_regulator(l1), .hv_domain_on(hvon), .lv_domain_on(lvon),
		.hv_domain_good(hvg), .lv_domain_good(lvg));

	pss_cpu_model #(.MS(MS)) cpu_u (.clk_sys(clk_sys), .srst(srst), .reset_out_n(rst_n), .battery_fault_n(flt_n),
		.hv_good(hvg), .lv_good(lvg), .use_serial(ser), .hv_en(hv), .lv_en(lv), .lv_ser(lvs), .ok(ok), .done(done));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// domains expected on after ms milliseconds of high-voltage enable
	function automatic logic [3:0] hv_expect(input logic d, input int ms);
		for (int i = 0; i < 4; i++)
			hv_expect[i] = (i == 0) || !d || (ms >= DOMAIN_STEP_MS * i);
	endfunction : hv_expect

	task automatic check_bit(input string nm, input logic [3:0] e, input logic [3:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : check_bit

	task automatic check_range(input string nm, input int lo, input int hi, input int g);
		total_checks++;
		if (g < lo || g > hi)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : check_range

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// bounded wait for reset_out_n to reach a level, t counts edges
	task automatic wait_rst(input logic lvl);
		t = 0;
		while (rst_n !== lvl && t < 400)
		begin
			@(posedge clk_sys);
			t++;
		end
	endtask : wait_rst

	task automatic run_seq;
		t = 0;
		while (hv !== 1'b1 && t < 100)
		begin
			@(posedge clk_sys);
			t++;
		end
		for (t = 0; l1 !== 1'b1 && t < 10; t++)
			@(posedge clk_sys);
		check_range("hv enable to first regulator", 2, 5, t);
		repeat (2) @(posedge clk_sys);
		check_bit("hv domains staggered", hv_expect(dly, 1), hvon);
		check_bit("hv good during ramp", 4'h0, hvg);
		for (t = 0; lv !== 1'b1 && lvs !== 1'b1 && t < 700; t++)
			@(posedge clk_sys);
		for (t = 0; lvon !== 3'h7 && t < 10; t++)
			@(posedge clk_sys);
		check_range("lv enable to lv domains", 1, ser ? 2 : 5, t);
		check_bit("lv good during ramp", 4'h0, {1'b0, lvg});
		for (t = 0; done !== 1'b1 && t < 700; t++)
			@(posedge clk_sys);
		check_bit("domain good seen by processor", 4'h1, {3'h0, ok});
		check_bit("hv good flags", 4'hF, hvg);
		check_bit("lv good flags", 4'h7, {1'b0, lvg});
		check_bit("hv domains all on", hv_expect(dly, 200), hvon);
		$display("test sequence delay %0d serial %0d done", dly, ser);
	endtask : run_seq

	// ----------------------------------------------------------------
	// battery fault follows the threshold one cycle later, every cycle outside reset and the cycle after it
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		cyc++;
		if (!srst && !srst_q)
			check_bit("battery_fault_n", {3'h0, bat_q}, {3'h0, flt_n});
		bat_q <= bat;
		srst_q <= srst;
		if (cyc == 10000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		// battery flickers while reset holds, so the processor must not start early
		for (t = 0; rst_n !== 1'b1 && t < 400; t++)
		begin
			@(posedge clk_sys);
			seed = xs(seed);
			bat <= (t < 150) ? seed[0] : 1'b1;
		end
		check_range("cold start reset hold", 200, 215, t);
		check_bit("backup regulator", 4'h1, {3'h0, bk});
		$display("test cold start done");
		for (int r = 0; r < 4; r++)
		begin
			// every stagger and enable-path pairing once; reset length stays random
			seed = xs(seed);
			dly <= r[0];
			ser <= r[1];
			run_seq();
			reset_in_n <= 1'b0;
			wait_rst(1'b0);
			check_range("reset in to reset out", 3, 5, t);
			repeat (seed[6:3] + 2) @(posedge clk_sys);
			check_bit("domains dropped", 4'h0, hvon | {1'b0, lvon});
			reset_in_n <= 1'b1;
			wait_rst(1'b1);
			check_range("hardware reset hold", 200, 215, t);
			$display("test hardware reset %0d done", r);
		end
		report_and_stop();
	end
endmodule : tb_top
